// ==== bench/cfr_chk_properties.sv ====
// Flag register checker.
`timescale 1ns/1ps
`default_nettype none
module cfr_chk
   import cfr_pkg::*;
(
   // Watched ports
   input wire logic hclk, hresetn, clk_en, hsel, hwrite, hready,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr, hrdata, hwdata,
   input wire cfr_alu_t alu_in,
   input wire logic [CFR_WORD_W-1:0] cpu_state_word,
   input wire logic bank_select, stack_select
);
   wire cfr_alu_t a = alu_in;
   wire [10:0] w = cpu_state_word;
   wire u = clk_en && a.valid;
   wire t = hsel && hready && htrans[1] && clk_en;
   wire tw = t && hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_b;
      tw && haddr[7:0] == CFR_OFF_WORD ##1 clk_en
         |=> bank_select == $past(hwdata[CFR_BIT_BANK]) &&
             bank_select == w[4];
   endproperty
   a_b: assert property (p_b) else $error("bank");
   property p_s;
      tw && haddr[7:0] == CFR_OFF_WORD ##1 clk_en
         |=> stack_select == $past(hwdata[CFR_BIT_STACK]) &&
             stack_select == w[7];
   endproperty
   a_s: assert property (p_s) else $error("stack");
   property p_m; (w & ~CFR_WORD_MASK) == 11'h000; endproperty
   a_m: assert property (p_m) else $error("mask");
   property p_c; u && a.upd_carry |=> w[0] == $past(a.carry); endproperty
   a_c: assert property (p_c) else $error("carry");
   property p_z; u && a.upd_zero |=> w[2] == !$past(a.result); endproperty
   a_z: assert property (p_z) else $error("zero");
   property p_n; u && a.upd_neg |=> w[3] == $past(a.result[15]); endproperty
   a_n: assert property (p_n) else $error("sign");
   property p_o; u && a.upd_ovf |=> w[5] == $past(a.ovf); endproperty
   a_o: assert property (p_o) else $error("ovf");
   property p_k; u && !a.upd_zero && !$past(tw) |=> $stable(w[2]); endproperty
   a_k: assert property (p_k) else $error("kept");
   property p_r; t && !hwrite && haddr == 0 |=> hrdata == 32'(w); endproperty
   a_r: assert property (p_r) else $error("read");
endmodule : cfr_chk
bind cfr_top cfr_chk u_chk(.hclk, .hresetn, .clk_en, .hsel, .hwrite,
   .hready, .htrans, .haddr, .hrdata, .hwdata, .alu_in, .cpu_state_word,
   .bank_select, .stack_select);
`default_nettype wire

// ==== bench/cpu_condition_flag_register_bench.sv ====
// Flag register bench.
`timescale 1ns/1ps
`default_nettype none
module cpu_condition_flag_register_bench;
   import cfr_pkg::*;
   logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hw = 0, rdy, rsp;
   logic [31:0] ha = 0, wd = 0, rd;
   logic [1:0] tr = 0;
   wire [1:0] bs;
   logic [10:0] q, ex = 0;
   cfr_alu_t al = '0, x;
   int err_total = 0, n_compared = 0;
   initial forever #5 hclk = ~hclk;
   cfr_top u_dut(.hclk, .hresetn, .clk_en(ce), .hsel, .haddr(ha),
      .htrans(tr), .hwrite(hw), .hsize(3'h2), .hready(rdy), .hwdata(wd),
      .hrdata(rd), .hreadyout(rdy), .hresp(rsp), .alu_in(al),
      .cpu_state_word(q), .bank_select(bs[1]), .stack_select(bs[0]));
   task chk(input logic [31:0] s, e);
      n_compared++;
      if (s !== e) $display("MISMATCH %0t %h %h", $time, s, e);
      err_total += s !== e;
   endtask : chk
   // The master waits on ready; the answer time is never assumed.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
      {hsel, hw, tr, ha} <= {1'b1, w, 2'h2, 24'h0, a};
      do @(posedge hclk); while (!rdy);
      {hsel, tr, wd} <= {3'h0, d};
      do @(posedge hclk); while (!rdy);
      if (!w) chk(rd, e);
      chk(rsp, 0);
   endtask : bus
   function logic [10:0] nxt(logic [10:0] w, cfr_alu_t x);
      if (x.upd_carry) w[0] = x.carry;
      if (x.upd_zero) w[2] = !x.result;
      if (x.upd_neg) w[3] = x.result[15];
      if (x.upd_ovf) w[5] = x.ovf;
      return w;
   endfunction : nxt
   task stop_test;
      $display("compared %0d failed %0d", n_compared, err_total);
      if (!err_total && n_compared) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial
   begin
      #9000 err_total++;
      stop_test;
   end
   initial
   begin
      void'($urandom(32'h2353_ef2d));
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      bus(0, 0, 0, 0);
      bus(1, 0, 32'hffff_fffd, 0);
      bus(0, 0, 0, 32'h0000_00bd);
      chk(bs, 3);
      bus(1, 0, 0, 0);
      bus(0, 0, 0, 0);
      chk(bs, 0);
      $display("regs done");
      // Zero results are forced often, since random ones rarely are.
      repeat (200)
      begin
         x = {1'b1, 6'($urandom), $urandom % 3 ? 16'($urandom) : 16'h0};
         ce <= $urandom % 4 > 0;
         al <= x;
         @(negedge hclk);
         chk(q, ex);
         @(posedge hclk);
         if (ce) ex = nxt(ex, x);
      end
      {al, ce} <= 1;
      @(negedge hclk);
      chk(q, ex);
      @(posedge hclk);
      bus(0, 4, 0, {ex[5], ex[3:2], ex[0]});
      bus(0, 8'h40, 0, 0);
      $display("alu done");
      stop_test;
   end
endmodule : cpu_condition_flag_register_bench
`default_nettype wire

// ==== src/cfr_flag_eval.sv ====
// Flag evaluation from an ALU result.
`timescale 1ns/1ps
`default_nettype none
module cfr_flag_eval
   import cfr_pkg::*;
#(
   parameter int unsigned DATA_W = 16
)
(
   // Result
   input wire cfr_alu_t alu,
   // Flags
   output cfr_flags_t flags
);

   always_comb
   begin
      flags.carry = alu.carry; // RULE2
      flags.zero = (alu.result[DATA_W-1:0] == '0); // RULE4
      flags.neg = alu.result[DATA_W-1]; // RULE5
      flags.ovf = alu.ovf; // RULE7
   end

endmodule : cfr_flag_eval
`default_nettype wire

// ==== src/cfr_pkg.sv ====
// Package of constants and types for the condition flag register block.
package cfr_pkg;

   // ****************************************
   // Word layout
   // ****************************************
   localparam int unsigned CFR_WORD_W = 11;
   localparam int unsigned CFR_BIT_CARRY = 0;
   localparam int unsigned CFR_BIT_TRAP = 1;
   localparam int unsigned CFR_BIT_ZERO = 2;
   localparam int unsigned CFR_BIT_NEG = 3;
   localparam int unsigned CFR_BIT_BANK = 4;
   localparam int unsigned CFR_BIT_OVF = 5;
   localparam int unsigned CFR_BIT_STACK = 7;
   localparam logic [10:0] CFR_WORD_RST = 11'h000;
   localparam logic [10:0] CFR_WORD_MASK = 11'h0bf;

   // ****************************************
   // Bus map
   // ****************************************
   localparam logic [7:0] CFR_OFF_WORD = 8'h00;
   localparam logic [7:0] CFR_OFF_STATUS = 8'h04;
   localparam logic [1:0] CFR_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] CFR_HTRANS_SEQ = 2'h3;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic valid;
      logic upd_carry;
      logic upd_zero;
      logic upd_neg;
      logic upd_ovf;
      logic carry;
      logic ovf;
      logic [15:0] result;
   } cfr_alu_t;

   typedef struct packed {
      logic carry;
      logic zero;
      logic neg;
      logic ovf;
   } cfr_flags_t;

   typedef enum logic [1:0] {CFR_DP_IDLE, CFR_DP_WRITE, CFR_DP_READ} cfr_dp_t;

endpackage : cfr_pkg

// ==== src/cfr_top.sv ====
// Condition flag register with AHB-Lite register access.
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - State word is an eleven bit register showing CPU state.
// RULE2 - Carry flag holds carry, borrow or shift-out from the ALU.
// RULE3 - Software keeps the trap bit at zero; debug use only.
// RULE4 - Zero flag is one for zero arithmetic result, else zero.
// RULE5 - Sign flag is one for negative arithmetic result, else zero.
// RULE6 - Bank bit picks register bank zero or bank one.
// RULE7 - Overflow flag is one on signed overflow, else zero.
// RULE8 - Stack bit picks application or handler stack pointer.
// RULE9 - Flags an instruction does not affect keep their values. Here a bus write to the word in the same cycle overwrites them.
module cfr_top
   import cfr_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // ALU side
   input wire cfr_alu_t alu_in,
   // Core state
   output logic [CFR_WORD_W-1:0] cpu_state_word,
   output logic bank_select,
   output logic stack_select
);

   // ****************************************
   // Address phase capture
   // ****************************************
   cfr_dp_t dp_q, dp_d;
   logic [7:0] addr_q, addr_d;
   logic [CFR_WORD_W-1:0] word_q, word_d;
   logic [31:0] rdata_q, rdata_d;
   cfr_flags_t flags;
   logic take;

   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input logic [10:0] w);
      logic [31:0] r;
      r = '0;
      if (a == CFR_OFF_WORD)
         r[CFR_WORD_W-1:0] = w;
      else if (a == CFR_OFF_STATUS)
         r[3:0] = {w[CFR_BIT_OVF], w[CFR_BIT_NEG], w[CFR_BIT_ZERO],
                   w[CFR_BIT_CARRY]};
      return r;
   endfunction : rd_mux

   cfr_flag_eval #(.DATA_W(16)) u_eval
   (
      .alu(alu_in),
      .flags(flags)
   );

   assign take = hsel && hready &&
                 (htrans == CFR_HTRANS_NONSEQ || htrans == CFR_HTRANS_SEQ);

   always_comb
   begin
      dp_d = dp_q;
      addr_d = addr_q;
      if (hready)
      begin
         dp_d = CFR_DP_IDLE;
         if (take)
         begin
            dp_d = hwrite ? CFR_DP_WRITE : CFR_DP_READ;
            addr_d = haddr[7:0];
         end
      end
   end

   // ****************************************
   // State word
   // ****************************************
   always_comb
   begin
      word_d = word_q; // RULE9
      if (dp_q == CFR_DP_WRITE && addr_q == CFR_OFF_WORD)
         word_d = hwdata[CFR_WORD_W-1:0] & CFR_WORD_MASK; // RULE1 RULE3
      if (alu_in.valid)
      begin
         // Flags not named by the instruction hold their value, or take hwdata when a bus write to the word lands in the same cycle.
         if (alu_in.upd_carry)
            word_d[CFR_BIT_CARRY] = flags.carry; // RULE2
         if (alu_in.upd_zero)
            word_d[CFR_BIT_ZERO] = flags.zero; // RULE4
         if (alu_in.upd_neg)
            word_d[CFR_BIT_NEG] = flags.neg; // RULE5
         if (alu_in.upd_ovf)
            word_d[CFR_BIT_OVF] = flags.ovf; // RULE7
      end
      rdata_d = rdata_q;
      if (take && !hwrite)
         rdata_d = rd_mux(haddr[7:0], word_d);
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_q <= CFR_DP_IDLE;
         addr_q <= '0;
         word_q <= CFR_WORD_RST;
         rdata_q <= '0;
      end
      else if (clk_en)
      begin
         dp_q <= dp_d;
         addr_q <= addr_d;
         word_q <= word_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Zero wait states keep the slave simple; unmapped reads return zero.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign cpu_state_word = word_q; // RULE1
   assign bank_select = word_q[CFR_BIT_BANK]; // RULE6
   assign stack_select = word_q[CFR_BIT_STACK]; // RULE8

endmodule : cfr_top
`default_nettype wire
